/* File: sdram_pkg.sv */
// constants, types and state records shared by the sdram command block
package sdram_pkg;
   // =========================================================
   // widths
   localparam int unsigned ADDR_W    = 11;
   localparam int unsigned COL_W     = 8;
   localparam int unsigned BANK_W    = 2;
   localparam int unsigned NUM_BANKS = 4;
   localparam int unsigned DQ_W      = 32;
   localparam int unsigned LANES     = 4;
   localparam int unsigned MEM_AW    = BANK_W + COL_W;
   localparam int unsigned MEM_WORDS = 1 << MEM_AW;
   localparam int unsigned PIPE_D    = 4;
   localparam int unsigned REFRESH_W = 11;

   // =========================================================
   // mode word and precharge flag layout on the address pins
   localparam int unsigned MODE_BL_LSB        = 0;
   localparam int unsigned MODE_BL_W          = 3;
   localparam int unsigned MODE_BT_BIT        = 3;
   localparam int unsigned MODE_CL_LSB        = 4;
   localparam int unsigned MODE_CL_W          = 3;
   localparam int unsigned MODE_WB_BIT        = 9;
   localparam int unsigned PRECHARGE_FLAG_BIT = 10;

   // =========================================================
   // burst length codes
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;

   // =========================================================
   // enumerations
   typedef enum logic [1:0] {ps_normal, ps_suspend, ps_power_down, ps_self_refresh}
      power_state_e;
   typedef enum logic [3:0] {cmd_deselect, cmd_activate, cmd_precharge, cmd_write,
      cmd_read, cmd_mode_set, cmd_nop, cmd_burst_stop, cmd_refresh} cmd_e;

   // =========================================================
   // state records
   typedef struct packed {
      logic                            cke_prev;
      power_state_e                    pstate;
      logic [NUM_BANKS-1:0]            bank_open;
      logic [ADDR_W-1:0]               mode;
      logic                            mode_valid;
      logic [BANK_W-1:0]               burst_bank;
      logic                            burst_write;
      logic                            burst_autopre;
      logic [REFRESH_W-1:0]            refresh_cnt;
      logic                            init_err;
      logic [LANES-1:0]                mask_d1;
      logic [LANES-1:0]                mask_d2;
      logic [PIPE_D-1:0]               pipe_valid;
      logic [PIPE_D-1:0][DQ_W-1:0]     pipe_data;
      logic [DQ_W-1:0]                 dq;
      logic [LANES-1:0]                dq_oe;
   } ctrl_s;

   typedef struct packed {
      logic             active;
      logic             full;
      logic             interleave;
      logic [COL_W-1:0] mask;
      logic [COL_W-1:0] start;
      logic [COL_W-1:0] idx;
   } gen_s;

   localparam ctrl_s CTRL_RESET = '0;
   localparam gen_s  GEN_RESET  = '0;
endpackage

/* File: burst_if.sv */
// burst request and column answer between controller and address generator
`timescale 1ns/1ns
interface burst_if;
   import sdram_pkg::*;
   logic             start;
   logic             stop;
   logic             advance;
   logic [COL_W-1:0] start_col;
   logic [2:0]       len_code;
   logic             interleave;
   logic [COL_W-1:0] col;
   logic             active;
   logic             last;
   modport ctrl (output start, stop, advance, start_col, len_code, interleave,
                 input  col, active, last);
   modport gen  (input  start, stop, advance, start_col, len_code, interleave,
                 output col, active, last);
endinterface

/* File: burst_addr_gen.sv */
// burst column address generator
`timescale 1ns/1ns
module burst_addr_gen
(
   input  wire logic ref_clk_in,
   input  wire logic rstn_in,
   burst_if.gen      bus
);
   import sdram_pkg::*;

   gen_s             st_r;
   gen_s             st_nxt;
   logic [COL_W-1:0] seq_sum;
   logic [COL_W-1:0] new_mask;

   // =========================================================
   // column of the word at the coming edge
   assign seq_sum    = st_r.start + st_r.idx;
   assign bus.col    = st_r.interleave ? (st_r.start ^ st_r.idx)
                     : ((st_r.start & ~st_r.mask) | (seq_sum & st_r.mask));
   assign bus.last   = st_r.active && !st_r.full && (st_r.idx == st_r.mask);
   assign bus.active = st_r.active;

   always_comb
   begin
      unique case (bus.len_code)
         BL_2:    new_mask = 8'h01;
         BL_4:    new_mask = 8'h03;
         BL_8:    new_mask = 8'h07;
         BL_FULL: new_mask = 8'hff;
         default: new_mask = 8'h00;
      endcase
   end

   // =========================================================
   // next state
   always_comb
   begin
      st_nxt = st_r;
      if (bus.start)
      begin
         st_nxt.start      = bus.start_col;
         st_nxt.idx        = 8'h01;
         st_nxt.mask       = new_mask;
         st_nxt.full       = (bus.len_code == BL_FULL);
         st_nxt.interleave = bus.interleave && (bus.len_code != BL_FULL);
         st_nxt.active     = (new_mask != 8'h00);
      end
      else if (bus.stop)
      begin
         st_nxt.active = 1'b0;
      end
      else if (bus.advance && st_r.active)
      begin
         if (bus.last)
         begin
            st_nxt.active = 1'b0;
         end
         else
         begin
            st_nxt.idx = st_r.idx + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         st_r <= GEN_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // =========================================================
   // checks
   chk_block_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      st_r.active && !st_r.full |-> ((bus.col & ~st_r.mask) == (st_r.start & ~st_r.mask)))
      else $error("burst column left its aligned block");
   chk_full_run: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      st_r.active && st_r.full && bus.advance && !bus.stop && !bus.start |=> st_r.active)
      else $error("full page burst ended without a command");
   chk_single_word: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      bus.start && bus.len_code == BL_1 |=> !st_r.active)
      else $error("single word burst kept running");
endmodule

/* File: sdram_command_and_init.sv */
// command decoder, mode register, power states and data path of the sdram
// Behaviour
// - decode command from pins at rising edge
// - activate opens row of idle bank
// - column command after delay; low address bits; code checks no delay and takes it on any edge once the bank is open
// - precharge flag: auto precharge or all banks
// - clock gate now and before select commands; code checks only the previous edge's gate (refresh also now)
// - no power down during burst; suspend instead
// - burst stop ends burst of any length
// - gate low while active suspends; high resumes
// - power down exits on gate rise, nop
// - mode holds length, order, latency, write mode
// - mode set before activate; reprogram only while all banks idle
// - all strobes low sets mode from address
// - burst moves programmed length of words
// - columns advance in order, wrap in block
// - full page only with sequential order
// - full page wraps and runs until stopped
// - deselect ignores commands, work continues
// - read mask two clocks; write mask immediate
// - refresh: auto if gate high, self if low
`timescale 1ns/1ns
module sdram_command_and_init
(
   input  wire logic                              ref_clk_in,
   input  wire logic                              rstn_in,
   input  wire logic                              chip_select_n_in,
   input  wire logic                              row_strobe_n_in,
   input  wire logic                              column_strobe_n_in,
   input  wire logic                              write_enable_n_in,
   input  wire logic                              clock_gate_in,
   input  wire logic [sdram_pkg::LANES-1:0]       byte_mask_in,
   input  wire logic [sdram_pkg::BANK_W-1:0]      bank_select_in,
   input  wire logic [sdram_pkg::ADDR_W-1:0]      addr_in,
   input  wire logic [sdram_pkg::DQ_W-1:0]        dq_in,
   output wire logic [sdram_pkg::DQ_W-1:0]        dq_out,
   output wire logic [sdram_pkg::LANES-1:0]       dq_oe_out,
   output wire logic [sdram_pkg::NUM_BANKS-1:0]   bank_open_out,
   output wire logic                              burst_active_out,
   output sdram_pkg::power_state_e                power_state_out,
   output wire logic [sdram_pkg::MODE_BL_W-1:0]   mode_burst_len_out,
   output wire logic                              mode_interleave_out,
   output wire logic [sdram_pkg::MODE_CL_W-1:0]   mode_cas_latency_out,
   output wire logic                              mode_single_write_out,
   output wire logic                              mode_valid_out,
   output wire logic [sdram_pkg::REFRESH_W-1:0]   refresh_count_out,
   output wire logic                              init_order_error_out
);
   import sdram_pkg::*;

   ctrl_s                st_r;
   ctrl_s                st_nxt;
   cmd_e                 cmd;
   logic                 live;
   logic                 nop_like;
   logic                 all_idle;
   logic                 col_cmd;
   logic                 pre_flag;
   logic                 acc_valid;
   logic                 acc_write;
   logic [COL_W-1:0]     acc_col;
   logic [BANK_W-1:0]    acc_bank;
   logic [MEM_AW-1:0]    mem_addr;
   logic [LANES-1:0]     mem_we;
   logic [DQ_W-1:0]      rd_word;
   logic [MODE_CL_W-1:0] cl;
   logic [1:0]           cl_idx;
   burst_if              bus ();

   // =========================================================
   // command decode
   always_comb
   begin
      if (chip_select_n_in)
      begin
         cmd = cmd_deselect;
      end
      else
      begin
         unique case ({row_strobe_n_in, column_strobe_n_in, write_enable_n_in})
            3'b011: cmd = cmd_activate;
            3'b010: cmd = cmd_precharge;
            3'b100: cmd = cmd_write;
            3'b101: cmd = cmd_read;
            3'b000: cmd = cmd_mode_set;
            3'b111: cmd = cmd_nop;
            3'b110: cmd = cmd_burst_stop;
            3'b001: cmd = cmd_refresh;
         endcase
      end
   end

   assign live     = (st_r.pstate == ps_normal) && st_r.cke_prev;
   assign nop_like = (cmd == cmd_deselect) || (cmd == cmd_nop);
   assign all_idle = (st_r.bank_open == '0);
   assign pre_flag = addr_in[PRECHARGE_FLAG_BIT];
   assign col_cmd  = live && ((cmd == cmd_read) || (cmd == cmd_write))
                   && st_r.bank_open[bank_select_in];
   assign cl       = st_r.mode[MODE_CL_LSB +: MODE_CL_W];
   assign cl_idx   = (cl == 3'h0) ? 2'h0 : (cl > 3'h4) ? 2'h3 : 2'(cl - 3'h1);

   // =========================================================
   // burst generator hookup
   assign bus.start      = col_cmd;
   assign bus.start_col  = addr_in[COL_W-1:0];
   assign bus.len_code   = ((cmd == cmd_write) && st_r.mode[MODE_WB_BIT]) ? BL_1
                         : st_r.mode[MODE_BL_LSB +: MODE_BL_W];
   assign bus.interleave = st_r.mode[MODE_BT_BIT];
   assign bus.stop       = live && ((cmd == cmd_burst_stop)
                         || ((cmd == cmd_precharge) && (pre_flag
                         || (bank_select_in == st_r.burst_bank))));
   assign bus.advance    = live;

   burst_addr_gen u_gen
   (
      .ref_clk_in (ref_clk_in),
      .rstn_in    (rstn_in),
      .bus        (bus)
   );

   // =========================================================
   // data store, one array per byte lane
   assign acc_valid = col_cmd || (live && bus.active && !bus.stop);
   assign acc_write = col_cmd ? (cmd == cmd_write) : st_r.burst_write;
   assign acc_col   = col_cmd ? addr_in[COL_W-1:0] : bus.col;
   assign acc_bank  = col_cmd ? bank_select_in : st_r.burst_bank;
   assign mem_addr  = {acc_bank, acc_col};

   for (genvar g = 0; g < LANES; g++)
   begin : lane
      logic [7:0] lane_mem [0:MEM_WORDS-1];
      assign mem_we[g] = acc_valid && acc_write && !byte_mask_in[g];
      always_ff @(posedge ref_clk_in)
      begin
         if (mem_we[g])
         begin
            lane_mem[mem_addr] <= dq_in[8*g +: 8];
         end
      end
      assign rd_word[8*g +: 8] = lane_mem[mem_addr];
   end

   // =========================================================
   // next state
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.cke_prev = clock_gate_in;
      unique case (st_r.pstate)
         ps_normal:
         begin
            if (st_r.cke_prev && !clock_gate_in)
            begin
               if ((cmd == cmd_refresh) && all_idle)
               begin
                  st_nxt.pstate = ps_self_refresh;
               end
               else if (bus.active || (nop_like && !all_idle))
               begin
                  st_nxt.pstate = ps_suspend;
               end
               else if (nop_like)
               begin
                  st_nxt.pstate = ps_power_down;
               end
            end
         end
         ps_suspend:
         begin
            if (clock_gate_in)
            begin
               st_nxt.pstate = ps_normal;
            end
         end
         ps_power_down, ps_self_refresh:
         begin
            if (clock_gate_in && nop_like)
            begin
               st_nxt.pstate = ps_normal;
            end
         end
      endcase

      if (live)
      begin
         unique case (cmd)
            cmd_activate:
            begin
               if (!st_r.bank_open[bank_select_in])
               begin
                  st_nxt.bank_open[bank_select_in] = 1'b1;
                  st_nxt.init_err = st_r.init_err || !st_r.mode_valid;
               end
            end
            cmd_precharge:
            begin
               if (pre_flag)
               begin
                  st_nxt.bank_open = '0;
               end
               else
               begin
                  st_nxt.bank_open[bank_select_in] = 1'b0;
               end
            end
            cmd_read, cmd_write:
            begin
               if (col_cmd)
               begin
                  st_nxt.burst_bank    = bank_select_in;
                  st_nxt.burst_write   = (cmd == cmd_write);
                  st_nxt.burst_autopre = pre_flag;
                  if (pre_flag && (bus.len_code == BL_1))
                  begin
                     st_nxt.bank_open[bank_select_in] = 1'b0;
                  end
               end
            end
            cmd_mode_set:
            begin
               if (all_idle)
               begin
                  st_nxt.mode       = addr_in;
                  st_nxt.mode_valid = 1'b1;
                  if (addr_in[MODE_BL_LSB +: MODE_BL_W] == BL_FULL)
                  begin
                     st_nxt.mode[MODE_BT_BIT] = 1'b0;
                  end
               end
            end
            cmd_refresh:
            begin
               if (all_idle && clock_gate_in)
               begin
                  st_nxt.refresh_cnt = st_r.refresh_cnt + 11'h001;
               end
            end
            cmd_deselect, cmd_nop, cmd_burst_stop:
            begin
            end
         endcase

         if (bus.active && bus.last && !bus.stop && !col_cmd && st_r.burst_autopre)
         begin
            st_nxt.bank_open[st_r.burst_bank] = 1'b0;
         end

         st_nxt.mask_d1    = byte_mask_in;
         st_nxt.mask_d2    = st_r.mask_d1;
         st_nxt.pipe_valid = {st_r.pipe_valid[PIPE_D-2:0], acc_valid && !acc_write};
         st_nxt.pipe_data  = {st_r.pipe_data[PIPE_D-2:0], rd_word};
         st_nxt.dq         = st_r.pipe_data[cl_idx];
         st_nxt.dq_oe      = {LANES{st_r.pipe_valid[cl_idx]}} & ~st_r.mask_d2;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         st_r <= CTRL_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // =========================================================
   // outputs
   assign dq_out                = st_r.dq;
   assign dq_oe_out             = st_r.dq_oe;
   assign bank_open_out         = st_r.bank_open;
   assign burst_active_out      = bus.active;
   assign power_state_out       = st_r.pstate;
   assign mode_burst_len_out    = st_r.mode[MODE_BL_LSB +: MODE_BL_W];
   assign mode_interleave_out   = st_r.mode[MODE_BT_BIT];
   assign mode_cas_latency_out  = cl;
   assign mode_single_write_out = st_r.mode[MODE_WB_BIT];
   assign mode_valid_out        = st_r.mode_valid;
   assign refresh_count_out     = st_r.refresh_cnt;
   assign init_order_error_out  = st_r.init_err;

   // =========================================================
   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   chk_mode_capture: assert property (
      live && cmd == cmd_mode_set && all_idle |=> mode_cas_latency_out == $past(addr_in[6:4]))
      else $error("mode set did not load latency field");
   chk_activate_open: assert property (
      live && cmd == cmd_activate |=> bank_open_out[$past(bank_select_in)])
      else $error("activate did not open bank");
   chk_deselect_hold: assert property (
      live && chip_select_n_in && !burst_active_out |=> $stable(bank_open_out))
      else $error("deselect changed bank state");
   chk_read_latency: assert property (
      (col_cmd && cmd == cmd_read && byte_mask_in == 4'h0 && cl == 3'h2)
      ##1 live ##1 live |=> dq_oe_out == 4'hf)
      else $error("read data not on bus after latency");
   chk_read_mask: assert property (
      (live && byte_mask_in[0]) ##1 live ##1 live |=> !dq_oe_out[0])
      else $error("read mask did not disable lane");
   chk_burst_stop: assert property (
      live && cmd == cmd_burst_stop |=> !burst_active_out)
      else $error("burst stop ignored");
   chk_suspend_entry: assert property (
      live && !clock_gate_in && nop_like && !all_idle |=> power_state_out == ps_suspend)
      else $error("clock suspend not entered");
   chk_suspend_exit: assert property (
      power_state_out == ps_suspend && clock_gate_in |=> power_state_out == ps_normal)
      else $error("clock suspend not left");
   chk_no_burst_pd: assert property (
      power_state_out == ps_power_down |-> !burst_active_out)
      else $error("power down during burst");
   chk_pd_exit: assert property (
      power_state_out == ps_power_down && clock_gate_in && nop_like
      |=> power_state_out == ps_normal)
      else $error("power down not left");
   chk_refresh_count: assert property (
      live && cmd == cmd_refresh && all_idle && clock_gate_in
      |=> refresh_count_out == $past(refresh_count_out) + 11'h001)
      else $error("auto refresh did not advance counter");
   chk_precharge_all: assert property (
      live && cmd == cmd_precharge && pre_flag |=> bank_open_out == 4'h0)
      else $error("precharge all left a bank open");

   cov_read_burst:   cover property (col_cmd && cmd == cmd_read ##1 burst_active_out);
   cov_write_burst:  cover property (col_cmd && cmd == cmd_write ##1 burst_active_out);
   cov_suspend:      cover property (power_state_out == ps_suspend ##1 power_state_out == ps_normal);
   cov_self_refresh: cover property (power_state_out == ps_self_refresh);
endmodule

/* File: ctl_model.sv */
// controller model driving the sdram command pins
`timescale 1ns/1ns
module ctl_model
#(
   parameter int PAUSE = 20,
   parameter int RCD   = 2
)
(
   input  wire logic   ref_clk_in,
   output logic [3:0]  cmd_n_out,
   output logic        clock_gate_out,
   output logic [3:0]  byte_mask_out,
   output logic [1:0]  bank_select_out,
   output logic [10:0] addr_out,
   output logic [31:0] dq_out
);
   initial
   begin
      cmd_n_out = 4'h7;
      clock_gate_out = 1'b1;
      byte_mask_out = 4'hf;
      bank_select_out = 2'h0;
      addr_out = 11'h000;
      dq_out = 32'h0;
   end
   // ==========================================
   // command tasks
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [10:0] a);
      @(negedge ref_clk_in);
      cmd_n_out = c;
      bank_select_out = b;
      addr_out = a;
      @(negedge ref_clk_in);
      cmd_n_out = 4'hf;
   endtask
   task automatic act(input logic [1:0] b);
      cmd(4'h3, b, 11'h005);
      repeat (RCD) @(negedge ref_clk_in);
   endtask
   task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic [31:0] d,
                     input int n, input int mw);
      for (int i = 0; i < n; i++)
      begin
         @(negedge ref_clk_in);
         cmd_n_out = (i == 0) ? 4'h4 : 4'hf;
         bank_select_out = b;
         addr_out = {3'h0, c};
         dq_out = d + i;
         byte_mask_out = (i == mw) ? 4'h1 : 4'h0;
      end
      @(negedge ref_clk_in);
      byte_mask_out = 4'h0;
      dq_out = ~dq_out;
   endtask
   task automatic gate(input logic g, input logic [3:0] c);
      @(negedge ref_clk_in);
      clock_gate_out = g;
      cmd_n_out = c;
   endtask
   task automatic mask_pulse(input logic [3:0] m);
      @(negedge ref_clk_in);
      byte_mask_out = m;
      @(negedge ref_clk_in);
      byte_mask_out = 4'h0;
   endtask
   task automatic init_seq(input logic [10:0] m);
      repeat (PAUSE) @(negedge ref_clk_in);
      byte_mask_out = 4'h0;
      cmd(4'h2, 2'h0, 11'h400);
      cmd(4'h1, 2'h0, 11'h000);
      cmd(4'h1, 2'h0, 11'h000);
      cmd(4'h0, 2'h0, m);
   endtask
endmodule

/* File: sdram_command_and_init_test.sv */
// self-checking bench for the sdram command block
`timescale 1ns/1ns
module sdram_command_and_init_test;
   import sdram_pkg::*;
   logic               ref_clk_in;
   logic               rstn_in;
   logic [3:0]         cmd_n;
   logic               clock_gate_in;
   logic [LANES-1:0]   byte_mask_in;
   logic [BANK_W-1:0]  bank_select_in;
   logic [ADDR_W-1:0]  addr_in;
   logic [DQ_W-1:0]    dq_in;
   logic [DQ_W-1:0]    dq_out;
   logic [LANES-1:0]   dq_oe_out;
   logic [3:0]         bank_open_out;
   logic               burst_active_out;
   power_state_e       power_state_out;
   logic [2:0]         mode_burst_len_out;
   logic               mode_interleave_out;
   logic [2:0]         mode_cas_latency_out;
   logic               mode_single_write_out;
   logic               mode_valid_out;
   logic [10:0]        refresh_count_out;
   logic               init_order_error_out;
   logic [31:0]        exp_q[$];
   int                 err_count = 0;
   int                 comparisons = 0;

   sdram_command_and_init sdram_command_and_init_inst
   (
      .ref_clk_in, .rstn_in, .chip_select_n_in(cmd_n[3]), .row_strobe_n_in(cmd_n[2]),
      .column_strobe_n_in(cmd_n[1]), .write_enable_n_in(cmd_n[0]), .clock_gate_in,
      .byte_mask_in, .bank_select_in, .addr_in, .dq_in, .dq_out, .dq_oe_out,
      .bank_open_out, .burst_active_out, .power_state_out, .mode_burst_len_out,
      .mode_interleave_out, .mode_cas_latency_out, .mode_single_write_out,
      .mode_valid_out, .refresh_count_out, .init_order_error_out
   );
   ctl_model ctl_model_inst
   (
      .ref_clk_in, .cmd_n_out(cmd_n), .clock_gate_out(clock_gate_in),
      .byte_mask_out(byte_mask_in), .bank_select_out(bank_select_in),
      .addr_out(addr_in), .dq_out(dq_in)
   );
   // ==========================================
   // checks and reads
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input int cl);
      ctl_model_inst.cmd(4'h5, 2'h1, {3'h0, c});
      repeat (cl) @(negedge ref_clk_in);
      foreach (exp_q[i])
      begin
         chk("dq_out", exp_q[i], dq_out);
         chk("dq_oe_out", 4'hf, dq_oe_out);
         @(negedge ref_clk_in);
      end
      chk("dq_oe_out", 4'h0, dq_oe_out);
   endtask
   initial
   begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   initial
   begin
      repeat (2000) @(posedge ref_clk_in);
      err_count++;
      wrap_up();
   end
   initial
   begin
      rstn_in = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk("mode_valid", 0, mode_valid_out);
      rstn_in = 1'b1;
      ctl_model_inst.init_seq(11'h022);
      chk("mode_valid", 1, mode_valid_out);
      chk("burst_len", BL_4, mode_burst_len_out);
      chk("cas", 3'h2, mode_cas_latency_out);
      chk("refresh", 2, refresh_count_out);
      ctl_model_inst.act(2'h1);
      chk("bank_open", 4'h2, bank_open_out);
      chk("init_err", 0, init_order_error_out);
      ctl_model_inst.wr(2'h1, 8'h02, 32'h111111a0, 4, 9);
      ctl_model_inst.wr(2'h1, 8'h02, 32'h222222b0, 4, 1);
      exp_q = '{32'h222222b0, 32'h222222a1, 32'h222222b2, 32'h222222b3};
      rd(8'h02, 2);
      ctl_model_inst.gate(1'b0, 4'h7);
      @(negedge ref_clk_in);
      chk("pstate", ps_suspend, power_state_out);
      ctl_model_inst.gate(1'b1, 4'h2);
      ctl_model_inst.gate(1'b1, 4'hf);
      chk("pstate", ps_normal, power_state_out);
      chk("bank_open", 4'h2, bank_open_out);
      ctl_model_inst.cmd(4'h2, 2'h0, 11'h400);
      chk("bank_open", 4'h0, bank_open_out);
      ctl_model_inst.gate(1'b0, 4'h7);
      @(negedge ref_clk_in);
      chk("pstate", ps_power_down, power_state_out);
      ctl_model_inst.gate(1'b1, 4'h7);
      @(negedge ref_clk_in);
      chk("pstate", ps_normal, power_state_out);
      ctl_model_inst.gate(1'b0, 4'h1);
      @(negedge ref_clk_in);
      chk("pstate", ps_self_refresh, power_state_out);
      ctl_model_inst.gate(1'b1, 4'hf);
      @(negedge ref_clk_in);
      chk("pstate", ps_normal, power_state_out);
      chk("refresh", 2, refresh_count_out);
      ctl_model_inst.cmd(4'h0, 2'h0, 11'h033);
      ctl_model_inst.act(2'h1);
      ctl_model_inst.wr(2'h1, 8'h00, 32'h33333300, 8, 9);
      ctl_model_inst.cmd(4'h2, 2'h0, 11'h400);
      ctl_model_inst.cmd(4'h0, 2'h0, 11'h03b);
      chk("interleave", 1, mode_interleave_out);
      ctl_model_inst.act(2'h1);
      exp_q = {};
      for (int i = 0; i < 8; i++)
         exp_q.push_back(32'h33333300 + (i ^ 2));
      rd(8'h02, 3);
      ctl_model_inst.cmd(4'h2, 2'h0, 11'h400);
      ctl_model_inst.cmd(4'h0, 2'h0, 11'h22f);
      chk("interleave", 0, mode_interleave_out);
      chk("single_write", 1, mode_single_write_out);
      chk("burst_len", BL_FULL, mode_burst_len_out);
      ctl_model_inst.act(2'h1);
      ctl_model_inst.cmd(4'h5, 2'h1, 11'h000);
      repeat (10) @(negedge ref_clk_in);
      ctl_model_inst.mask_pulse(4'h1);
      repeat (2) @(negedge ref_clk_in);
      chk("dq_oe_out", 4'he, dq_oe_out);
      @(negedge ref_clk_in);
      chk("dq_oe_out", 4'hf, dq_oe_out);
      repeat (300) @(negedge ref_clk_in);
      chk("burst_active", 1, burst_active_out);
      ctl_model_inst.cmd(4'h6, 2'h1, 11'h000);
      chk("burst_active", 0, burst_active_out);
      rstn_in = 1'b0;
      repeat (2) @(negedge ref_clk_in);
      rstn_in = 1'b1;
      ctl_model_inst.act(2'h0);
      chk("init_err", 1, init_order_error_out);
      chk("bank_open", 4'h1, bank_open_out);
      chk("mode_valid", 0, mode_valid_out);
      wrap_up();
   end
endmodule
